// ### hdl/prc_op_control.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
// Function
// R1: setting the launch bit starts a self-timed operation and hardware clears the bit when it is finished.
// R2: software can only set the launch bit; a written zero is ignored and only completion, termination or power-on reset clears it.
// R3: the modify-permit bit must be one for any program or erase to run, else all are inhibited.
// R4: the sequence fault flag is set on a faulty launch attempt or a terminated operation.
// R5: with idle standby set the regulator goes to standby during Idle, otherwise it stays active.
// R6: with idle standby set, the memory is held not ready after Idle exit for the regulator wake delay.
// R7: the swap-done bit reads one once a panel swap instruction has completed, zero while awaited.
// R8: the second-panel-active bit reads one while panel 2 is mapped into the active region.
// R9: the row-format bit tells the array whether row data is compressed or not.
// R10: a row operation that runs short of data is terminated and sets the underrun error bit.
// R11: the operation field is the low four bits, only defined codes run, and bits 7 to 4 read zero.
// R12: launch, permit, fault and operation bits are cleared only by power-on reset.
// R13: the power-save instruction is ignored while any operation is in progress.
// R14: a double-word program writes two words on a 4-word aligned boundary in one operation.
// R15: a launch with the modify-permit bit clear does not start and sets the sequence fault flag.
module prc_op_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic cpu_idle,
  input wire logic power_save_instruction,
  output logic power_save_granted,
  output logic regulator_standby,
  output logic program_ram_ready,
  input wire logic panel_swap_instruction,
  input wire logic row_data_short,
  input wire logic [1:0] target_word_offset,
  output logic array_op_start,
  output logic array_op_abort,
  output logic [3:0] array_op_code,
  output logic array_compressed,
  output logic array_busy
);

  // ****************************************
  // state
  // ****************************************
  logic launch;
  logic modify_permit;
  logic sequence_fault_flag;
  logic regulator_idle_standby;
  logic panel_swap_done;
  logic second_panel_active;
  logic row_compressed_format;
  logic row_underrun_error;
  logic [3:0] operation_select;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic cpu_idle_q;
  logic wake_running;
  logic op_done;
  logic any_rst;

  // ****************************************
  // bus decode
  // ****************************************
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire hit_ctrl = (paddr == prc_pkg::OFF_CTRL);
  wire hit_status = (paddr == prc_pkg::OFF_IRQ_STATUS);
  wire hit_mask = (paddr == prc_pkg::OFF_IRQ_MASK);
  wire mapped = hit_ctrl || hit_status || hit_mask;
  wire wr_ctrl = access && pwrite && hit_ctrl;
  wire wr_status = access && pwrite && hit_status;
  wire wr_mask = access && pwrite && hit_mask;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign any_rst = rst || por_rst;

  // ****************************************
  // launch decision
  // ****************************************
  wire [3:0] wr_op = pwdata[prc_pkg::OP_MSB:prc_pkg::OP_LSB];
  wire wr_permit = pwdata[prc_pkg::BIT_PERMIT];
  wire launch_try = wr_ctrl && pwdata[prc_pkg::BIT_LAUNCH] && !launch;
  wire op_known = (wr_op == prc_pkg::OP_DWORD) || (wr_op == prc_pkg::OP_ROW) ||
                  (wr_op == prc_pkg::OP_PAGE_ERASE) || (wr_op == prc_pkg::OP_BULK_ERASE);
  wire dword_bad = (wr_op == prc_pkg::OP_DWORD) && (target_word_offset != prc_pkg::DWORD_ALIGN);
  wire start_ok = launch_try && wr_permit && op_known && !dword_bad;
  wire launch_bad = launch_try && !start_ok;
  // dropping the permit mid operation is a termination, not a pause
  wire permit_drop = launch && wr_ctrl && !wr_permit;
  wire underrun_ev = launch && row_data_short && (operation_select == prc_pkg::OP_ROW);
  wire terminate = permit_drop || underrun_ev;
  wire fault_ev = launch_bad || terminate;

  prc_pkg::prc_count_t op_cycles;
  assign op_cycles = (wr_op == prc_pkg::OP_DWORD) ? prc_pkg::DWORD_CYC :
                     (wr_op == prc_pkg::OP_ROW) ? prc_pkg::ROW_CYC :
                     (wr_op == prc_pkg::OP_PAGE_ERASE) ? prc_pkg::PAGE_ERASE_CYC : prc_pkg::BULK_ERASE_CYC;

  // the op timer only follows power-on reset, like the launch bit it drives
  prc_cycle_timer u_op_timer (
    .clk(clk),
    .rst(por_rst),
    .load(start_ok),
    .abort(terminate),
    .load_val(op_cycles),
    .running(),
    .done(op_done)
  );

  // ****************************************
  // power-on-only bits
  // ****************************************
  always_ff @(posedge clk) begin
    if (por_rst) begin // R12
      launch <= 1'b0;
      modify_permit <= 1'b0;
      sequence_fault_flag <= 1'b0;
      operation_select <= 4'h0;
    end else begin
      if (start_ok) begin // R1 R3 R14
        launch <= 1'b1;
      end else if (op_done || terminate) begin // R1 R2
        launch <= 1'b0;
      end
      if (wr_ctrl) begin
        modify_permit <= wr_permit; // R3
      end
      if (fault_ev) begin // R4 R15
        sequence_fault_flag <= 1'b1;
      end else if (wr_ctrl) begin
        sequence_fault_flag <= pwdata[prc_pkg::BIT_FAULT];
      end
      if (wr_ctrl && !launch) begin // R11
        operation_select <= wr_op;
      end
    end
  end

  // ****************************************
  // bits cleared by any reset
  // ****************************************
  always_ff @(posedge clk) begin
    if (any_rst) begin
      regulator_idle_standby <= 1'b0;
      row_compressed_format <= 1'b0;
      row_underrun_error <= 1'b0;
      panel_swap_done <= 1'b0;
      second_panel_active <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        regulator_idle_standby <= pwdata[prc_pkg::BIT_STANDBY];
      end
      if (wr_ctrl && !launch) begin // R9
        row_compressed_format <= pwdata[prc_pkg::BIT_COMPRESSED];
      end
      if (underrun_ev) begin // R10
        row_underrun_error <= 1'b1;
      end else if (wr_ctrl && !pwdata[prc_pkg::BIT_UNDERRUN]) begin
        row_underrun_error <= 1'b0;
      end
      if (panel_swap_instruction) begin // R7
        panel_swap_done <= 1'b1;
      end else if (wr_ctrl && !pwdata[prc_pkg::BIT_SWAP_DONE]) begin
        panel_swap_done <= 1'b0;
      end
      if (panel_swap_instruction) begin // R8
        second_panel_active <= !second_panel_active;
      end
    end
  end

  // ****************************************
  // array side
  // ****************************************
  assign array_busy = launch;
  assign array_op_abort = terminate;

  always_ff @(posedge clk) begin
    if (por_rst) begin
      array_op_start <= 1'b0;
      array_op_code <= 4'h0;
      array_compressed <= 1'b0;
    end else begin
      array_op_start <= start_ok; // R1
      if (start_ok) begin
        array_op_code <= wr_op;
        array_compressed <= pwdata[prc_pkg::BIT_COMPRESSED]; // R9
      end
    end
  end

  // ****************************************
  // idle, standby and wake
  // ****************************************
  wire idle_exit = cpu_idle_q && !cpu_idle;
  wire wake_start = idle_exit && regulator_idle_standby;

  prc_cycle_timer u_wake_timer (
    .clk(clk),
    .rst(any_rst),
    .load(wake_start),
    .abort(1'b0),
    .load_val(prc_pkg::WAKE_CYC),
    .running(wake_running),
    .done()
  );

  // an operation blocks sleep entry; the core sees the instruction as a no-op
  assign power_save_granted = power_save_instruction && !launch; // R13
  assign regulator_standby = cpu_idle && regulator_idle_standby; // R5
  // the memory stays unusable from idle exit until the wake count runs out
  assign program_ram_ready = !regulator_standby && !wake_start && !wake_running; // R6

  always_ff @(posedge clk) begin
    if (any_rst) begin
      cpu_idle_q <= 1'b0;
    end else begin
      cpu_idle_q <= cpu_idle;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [3:0] irq_set;
  assign irq_set[prc_pkg::IRQ_OP_DONE] = op_done;
  assign irq_set[prc_pkg::IRQ_FAULT] = fault_ev;
  assign irq_set[prc_pkg::IRQ_UNDERRUN] = underrun_ev;
  assign irq_set[prc_pkg::IRQ_SWAP] = panel_swap_instruction;
  wire [3:0] irq_clr = wr_status ? pwdata[prc_pkg::IRQ_W-1:0] : 4'h0;
  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clk) begin
    if (any_rst) begin
      irq_status <= prc_pkg::IRQ_RESET;
      irq_mask <= prc_pkg::IRQ_RESET;
    end else begin
      // a set in the clearing cycle survives
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_mask) begin
        irq_mask <= pwdata[prc_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [15:0] ctrl_word;
  always_comb begin
    ctrl_word = prc_pkg::CTRL_RESET;
    ctrl_word[prc_pkg::BIT_LAUNCH] = launch;
    ctrl_word[prc_pkg::BIT_PERMIT] = modify_permit;
    ctrl_word[prc_pkg::BIT_FAULT] = sequence_fault_flag;
    ctrl_word[prc_pkg::BIT_STANDBY] = regulator_idle_standby;
    ctrl_word[prc_pkg::BIT_SWAP_DONE] = panel_swap_done;
    ctrl_word[prc_pkg::BIT_PANEL2] = second_panel_active;
    ctrl_word[prc_pkg::BIT_COMPRESSED] = row_compressed_format;
    ctrl_word[prc_pkg::BIT_UNDERRUN] = row_underrun_error;
    ctrl_word[prc_pkg::OP_MSB:prc_pkg::OP_LSB] = operation_select; // R11
  end

  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_word} :
                       hit_status ? {28'h0000000, irq_status} :
                       hit_mask ? {28'h0000000, irq_mask} : 32'h00000000;

  // sampled in the setup cycle so the access phase answers with zero wait
  always_ff @(posedge clk) begin
    if (any_rst) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por_rst);

  sequence s_good_launch;
    start_ok ##1 array_op_start;
  endsequence

  sequence s_run_then_done;
    launch && op_done ##1 !launch;
  endsequence

  property p_launch_starts;
    start_ok |-> s_good_launch ##0 launch;
  endproperty
  a_launch_starts: assert property (p_launch_starts) else $error("launch did not start"); // R1

  property p_done_clears;
    launch && op_done |-> s_run_then_done;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("launch not cleared"); // R1

  property p_no_sw_clear;
    launch && wr_ctrl && !pwdata[prc_pkg::BIT_LAUNCH] && wr_permit && !op_done && !underrun_ev |=> launch;
  endproperty
  a_no_sw_clear: assert property (p_no_sw_clear) else $error("software cleared launch"); // R2

  property p_permit_gate;
    array_op_start |-> $past(wr_permit) && $past(wr_ctrl);
  endproperty
  a_permit_gate: assert property (p_permit_gate) else $error("start without permit"); // R3

  property p_bad_faults;
    launch_try && !wr_permit |=> sequence_fault_flag && !launch && !array_op_start;
  endproperty
  a_bad_faults: assert property (p_bad_faults) else $error("bad launch not flagged"); // R15

  property p_term_faults;
    permit_drop |=> sequence_fault_flag && !launch;
  endproperty
  a_term_faults: assert property (p_term_faults) else $error("termination not flagged"); // R4

  property p_standby;
    !regulator_idle_standby |-> !regulator_standby;
  endproperty
  a_standby: assert property (p_standby) else $error("standby without enable"); // R5

  property p_wake;
    wake_start |-> !program_ram_ready [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("ram ready too soon"); // R6

  property p_swap;
    panel_swap_instruction |=> panel_swap_done && (second_panel_active != $past(second_panel_active));
  endproperty
  a_swap: assert property (p_swap) else $error("swap not reported"); // R7

  property p_underrun;
    underrun_ev |=> row_underrun_error && !launch && irq_status[prc_pkg::IRQ_UNDERRUN];
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not reported"); // R10

  // checked on the registered read path; the bits of the control word alone are zero by construction
  property p_rsvd;
    setup && !pwrite && hit_ctrl |=> (prdata[7:4] == 4'h0) && (prdata[31:16] == 16'h0000);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero"); // R11

  property p_psave;
    launch |-> !power_save_granted;
  endproperty
  a_psave: assert property (p_psave) else $error("sleep granted while busy"); // R13

  property p_dword;
    array_op_start && (array_op_code == prc_pkg::OP_DWORD) |-> $past(target_word_offset) == prc_pkg::DWORD_ALIGN;
  endproperty
  a_dword: assert property (p_dword) else $error("unaligned double word"); // R14

endmodule

// ### hdl/prc_pkg.sv
package prc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int BIT_LAUNCH = 15;
  localparam int BIT_PERMIT = 14;
  localparam int BIT_FAULT = 13;
  localparam int BIT_STANDBY = 12;
  localparam int BIT_SWAP_DONE = 11;
  localparam int BIT_PANEL2 = 10;
  localparam int BIT_COMPRESSED = 9;
  localparam int BIT_UNDERRUN = 8;
  localparam int OP_MSB = 3;
  localparam int OP_LSB = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ****************************************
  // interrupt status fields
  // ****************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_OP_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_UNDERRUN = 2;
  localparam int IRQ_SWAP = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ****************************************
  // operation codes
  // ****************************************
  localparam logic [3:0] OP_DWORD = 4'h1;
  localparam logic [3:0] OP_ROW = 4'h2;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_BULK_ERASE = 4'he;
  localparam logic [1:0] DWORD_ALIGN = 2'h0;

  // ****************************************
  // timing
  // ****************************************
  typedef logic [11:0] prc_count_t;
  localparam int CLK_NS = 4;
  localparam int DWORD_NS = 1000;
  localparam int ROW_NS = 4000;
  localparam int PAGE_ERASE_NS = 8000;
  localparam int BULK_ERASE_NS = 16000;
  localparam int WAKE_NS = 400;
  localparam prc_count_t DWORD_CYC = prc_count_t'((DWORD_NS + CLK_NS - 1) / CLK_NS);
  localparam prc_count_t ROW_CYC = prc_count_t'((ROW_NS + CLK_NS - 1) / CLK_NS);
  localparam prc_count_t PAGE_ERASE_CYC = prc_count_t'((PAGE_ERASE_NS + CLK_NS - 1) / CLK_NS);
  localparam prc_count_t BULK_ERASE_CYC = prc_count_t'((BULK_ERASE_NS + CLK_NS - 1) / CLK_NS);
  localparam prc_count_t WAKE_CYC = prc_count_t'((WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam prc_count_t COUNT_ZERO = 12'h000;
  localparam prc_count_t COUNT_ONE = 12'h001;

endpackage

// ### hdl/prc_cycle_timer.sv
`timescale 1ns/1ps
module prc_cycle_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic abort,
  input wire prc_pkg::prc_count_t load_val,
  output logic running,
  output logic done
);

  prc_pkg::prc_count_t count;
  prc_pkg::prc_count_t next_count;

  // ****************************************
  // down counter, load wins over abort
  // ****************************************
  assign running = (count != prc_pkg::COUNT_ZERO);
  assign done = (count == prc_pkg::COUNT_ONE) && !abort && !load;

  always_comb begin
    if (load) begin
      next_count = load_val;
    end else if (abort) begin
      next_count = prc_pkg::COUNT_ZERO;
    end else if (running) begin
      next_count = count - prc_pkg::COUNT_ONE;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= prc_pkg::COUNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ### testbench/prc_array_model.sv
`timescale 1ns/1ps
// ****************************************
// program ram array stand-in
// ****************************************
module prc_array_model #(
  parameter int SHORT_AT = 20
) (
  input wire logic clk,
  input wire logic array_op_start,
  input wire logic [3:0] array_op_code,
  input wire logic array_compressed,
  input wire logic array_busy,
  input wire logic starve,
  output logic row_data_short,
  output logic [3:0] seen_code,
  output logic seen_comp,
  output int starts
);
  int cnt;
  initial begin
    row_data_short = 1'b0;
    seen_code = 4'h0;
    seen_comp = 1'b0;
    starts = 0;
    cnt = 0;
  end
  // runs short of row data only when the bench asks, once per operation
  always @(posedge clk) begin
    row_data_short <= 1'b0;
    if (array_busy === 1'b1) begin
      seen_code <= array_op_code;
      seen_comp <= array_compressed;
      cnt <= cnt + 1;
      if (starve && array_op_code == prc_pkg::OP_ROW && cnt == SHORT_AT) row_data_short <= 1'b1;
    end
    if (array_op_start === 1'b1) begin
      starts <= starts + 1;
      cnt <= 0;
    end
  end
endmodule

// ### testbench/test_program_ram_op_control.sv
`timescale 1ns/1ps
module test_program_ram_op_control;
  logic clk = 0, rst = 1, por_rst = 1, psel = 0, penable = 0, pwrite = 0, e, p;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, cpu_idle = 0, power_save_instruction = 0, power_save_granted;
  logic regulator_standby, program_ram_ready, panel_swap_instruction = 0, row_data_short, starve = 0;
  logic [1:0] target_word_offset = 2'h0;
  logic array_op_start, array_op_abort, array_compressed, array_busy, seen_comp;
  logic [3:0] array_op_code, seen_code, op;
  int err_total = 0, checked = 0, seed = 32'h3927, n, s0, aborts = 0, starts, d;
  `define CHK(nm, ex, sv) begin checked++; if ((sv) !== (ex)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, ex, sv); end end
  localparam logic [7:0] CT = prc_pkg::OFF_CTRL;
  localparam logic [7:0] ST = prc_pkg::OFF_IRQ_STATUS;

  always #2 clk = ~clk;
  always @(posedge clk) if (array_op_abort === 1'b1) aborts <= aborts + 1;

  prc_op_control dut (.clk(clk), .rst(rst), .por_rst(por_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .cpu_idle(cpu_idle), .power_save_instruction(power_save_instruction),
    .power_save_granted(power_save_granted), .regulator_standby(regulator_standby),
    .program_ram_ready(program_ram_ready), .panel_swap_instruction(panel_swap_instruction),
    .row_data_short(row_data_short), .target_word_offset(target_word_offset),
    .array_op_start(array_op_start), .array_op_abort(array_op_abort), .array_op_code(array_op_code),
    .array_compressed(array_compressed), .array_busy(array_busy));
  prc_array_model model (.clk(clk), .array_op_start(array_op_start), .array_op_code(array_op_code),
    .array_compressed(array_compressed), .array_busy(array_busy), .starve(starve),
    .row_data_short(row_data_short), .seen_code(seen_code), .seen_comp(seen_comp), .starts(starts));

  // ****************************************
  // bus and helpers
  // ****************************************
  // one extra idle edge after release keeps back-to-back calls from double driving psel
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] ex, input logic [15:0] m, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, r[15:0] & m)
  endtask
  task automatic wait_idle;
    n = 0;
    while (array_busy === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic legal(input logic [3:0] o, input logic [1:0] off);
    return (o == prc_pkg::OP_DWORD && off == prc_pkg::DWORD_ALIGN) || o == prc_pkg::OP_ROW ||
      o == prc_pkg::OP_PAGE_ERASE || o == prc_pkg::OP_BULK_ERASE;
  endfunction
  function automatic int dur(input logic [3:0] o);
    return o == prc_pkg::OP_DWORD ? 250 : o == prc_pkg::OP_ROW ? 1000 : o == prc_pkg::OP_PAGE_ERASE ? 2000 : 4000;
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    @(posedge clk);
    rdc(CT, prc_pkg::CTRL_RESET, 16'hffff, "ctrl after por");
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    apb(1'b1, prc_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b1, CT, 32'h8001);
    rdc(CT, 16'h2001, 16'hffff, "launch no permit");
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, prc_pkg::OFF_IRQ_MASK, 32'hf);
    `CHK("irq fault", 1'b1, irq)
    apb(1'b1, ST, 32'hf);
    `CHK("irq cleared", 1'b0, irq)
    $display("end of test permit");
    power_save_instruction <= 1'b1;
    apb(1'b1, CT, 32'h0);
    apb(1'b1, CT, 32'hc001);
    `CHK("grant busy", 1'b0, power_save_granted)
    apb(1'b1, CT, 32'h4001);
    rdc(CT, 16'hc001, 16'hffff, "zero write on launch");
    wait_idle;
    rdc(CT, 16'h4001, 16'hffff, "after completion");
    `CHK("grant idle", 1'b1, power_save_granted)
    rdc(ST, 16'h0001, 16'hffff, "done status");
    `CHK("irq done", 1'b1, irq)
    apb(1'b1, ST, 32'hf);
    power_save_instruction <= 1'b0;
    $display("end of test launch");
    for (int i = 0; i < 17; i++) begin
      op = (i == 16) ? 4'h1 : i[3:0];
      target_word_offset <= (i == 1) ? 2'h0 : (i == 16 ? 2'h3 : 2'($random(seed)));
      apb(1'b1, CT, 32'h0);
      s0 = starts;
      apb(1'b1, CT, 32'hc000 | op);
      wait_idle;
      d = dur(op);
      `CHK("starts", legal(op, target_word_offset) ? 1 : 0, starts - s0)
      `CHK("op time", 1'b1, legal(op, target_word_offset) ? (n >= d - 2 && n <= d + 2) : n == 0)
      if (legal(op, target_word_offset)) `CHK("array code", op, seen_code)
      rdc(CT, (legal(op, target_word_offset) ? 16'h4000 : 16'h6000) | op, 16'hffff, "op result");
      apb(1'b1, ST, 32'hf);
    end
    $display("end of test codes");
    apb(1'b1, CT, 32'h0);
    s0 = aborts;
    apb(1'b1, CT, 32'hc002);
    apb(1'b1, CT, 32'h0002);
    rdc(CT, 16'h2002, 16'hffff, "terminated");
    `CHK("abort pulse", 1, aborts - s0)
    apb(1'b1, CT, 32'h0);
    starve <= 1'b1;
    apb(1'b1, CT, 32'hc202);
    wait_idle;
    starve <= 1'b0;
    rdc(CT, 16'h6302, 16'hffff, "underrun");
    `CHK("compressed", 1'b1, seen_comp)
    $display("end of test abort");
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, CT, 32'h0);
      p = r[10];
      panel_swap_instruction <= 1'b1;
      @(posedge clk);
      panel_swap_instruction <= 1'b0;
      @(posedge clk);
      rdc(CT, {4'h0, 1'b1, ~p, 10'h0}, 16'h0c00, "swap");
    end
    $display("end of test swap");
    apb(1'b1, CT, 32'h1000);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("standby", 1'b1, regulator_standby)
    cpu_idle <= 1'b0;
    n = 0;
    while (program_ram_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    `CHK("wake delay", 1'b1, n >= 98 && n <= 103)
    apb(1'b1, CT, 32'h0);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("no standby", 1'b0, regulator_standby)
    `CHK("ready in idle", 1'b1, program_ram_ready)
    cpu_idle <= 1'b0;
    $display("end of test idle");
    apb(1'b1, CT, 32'h4003);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(CT, 16'h4003, 16'he00f, "kept over reset");
    por_rst <= 1'b1;
    repeat (2) @(posedge clk);
    por_rst <= 1'b0;
    @(posedge clk);
    rdc(CT, 16'h0000, 16'hffff, "cleared by por");
    $display("end of test reset");
    summarize;
  end

  // the slowest pass is the code sweep, under 10000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    summarize;
  end
endmodule
